//--- rtl/jfp_access.sv
// Scan-port flash programming access: test-access controller, reset,
// unlock, command and page-load data registers.
// Assumes tck/tms/tdi/ext_rst_n come from pins, the rest from sys_clk logic.
//
// How it works
// R01: The programmer uses only the four test-port pins, never reset or clock.
// R02: The port works only with the enable fuse set and disable bit clear.
// R03: Disable bit set and external reset low: bit clears after two clocks.
// R04: All shift registers move least significant bit first, in and out.
// R05: The instruction register is four bits wide, sixteen opcodes.
// R06: Run-Test/Idle makes internal programming clocks and is a safe idle.
// R07: Opcode 0xC selects the one-bit reset register; controller not reset.
// R08: Device stays in reset while the reset register holds one.
// R09: Opcode 0x4 selects the sixteen-bit unlock register, shifted in Shift-DR.
// R10: Update-DR under unlock compares pattern; a match enters programming.
// R11: Unlock key is 0xA370; register clears on reset; programmer clears it.
// R12: Reset bit acts like the reset pin, then a time-out follows release.
// R13: Opcode 0x5 selects the fifteen-bit command register.
// R14: Capture-DR under command loads the previous command's result.
// R15: Shift-DR moves old result out while the new command enters.
// R16: Update-DR presents the command word to the memory control inputs.
// R17: Entering Run-Test/Idle under command gives one execute clock.
// R18: Programmer sends write-flash and address-byte commands by fixed prefixes.
// R19: Opcode 0x6 selects the low eight command bits as page data register.
// R20: Page-load Update-DR holds the byte and writes the page buffer quickly.
// R21: Page-load updates alternate low then high byte, low first.
// R22: Word address increments before each low byte except the first.
// R23: Commands and page loads do nothing until unlock succeeds.
`include "jfp_cfg.svh"
module jfp_access (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Test-port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // External reset pin and fuse
  input wire logic ext_rst_n,
  input wire logic scan_port_enable_fuse,
  // Disable bit of the mcu_control_status_reg, written by the core
  input wire logic dis_wr,
  input wire logic dis_wr_val,
  output logic scan_port_disable_bit,
  // Device reset and programming state
  output logic dev_reset,
  output logic prog_mode,
  // Memory control side
  input wire logic [`JFP_CMD_W-1:0] cmd_result,
  output jfp_pkg::jfp_cmd_type nvm_cmd,
  output logic nvm_exec_clk,
  output jfp_pkg::jfp_pbuf_type pbuf_wr
);
  // ==========================================================
  // Pin synchroniser and edge detect
  jfp_pkg::jfp_pin_type pin_s1_ff;
  jfp_pkg::jfp_pin_type pin_s2_ff;
  logic tck_prev_ff;
  wire jfp_pkg::jfp_pin_type pin_raw = {tck, tms, tdi, ext_rst_n};
  wire tck_rise = pin_s2_ff.tck & ~tck_prev_ff;
  wire tck_fall = ~pin_s2_ff.tck & tck_prev_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_s1_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, ext_rst_n: 1'b1};
      pin_s2_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, ext_rst_n: 1'b1};
      tck_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      tck_prev_ff <= pin_s2_ff.tck;
    end
  end

  // ==========================================================
  // Port disable bit
  logic dis_ff;
  logic [1:0] dis_cnt_ff;
  logic [1:0] nxt_dis_cnt;
  logic nxt_dis;
  wire dis_rst_low = dis_ff & ~pin_s2_ff.ext_rst_n;
  wire dis_clr = dis_rst_low & (dis_cnt_ff == `JFP_DIS_CLR_CYC - 2'h1);
  wire port_en = scan_port_enable_fuse & ~dis_ff; // R02

  always_comb begin
    nxt_dis = dis_ff;
    nxt_dis_cnt = 2'h0;
    if (dis_rst_low && !dis_clr) begin
      nxt_dis_cnt = dis_cnt_ff + 2'h1;
    end
    if (dis_clr) begin
      nxt_dis = 1'b0; // R03
    end
    if (dis_wr) begin
      nxt_dis = dis_wr_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dis_ff <= 1'b0;
      dis_cnt_ff <= 2'h0;
    end else begin
      dis_ff <= nxt_dis;
      dis_cnt_ff <= nxt_dis_cnt;
    end
  end

  // ==========================================================
  // Test-access controller
  function automatic jfp_pkg::jfp_tap_type tap_next(
    input jfp_pkg::jfp_tap_type s, input logic m);
    case (s)
      jfp_pkg::TLR: tap_next = m ? jfp_pkg::TLR : jfp_pkg::RTI;
      jfp_pkg::RTI: tap_next = m ? jfp_pkg::SEL_DR : jfp_pkg::RTI;
      jfp_pkg::SEL_DR: tap_next = m ? jfp_pkg::SEL_IR : jfp_pkg::CAP_DR;
      jfp_pkg::CAP_DR: tap_next = m ? jfp_pkg::EX1_DR : jfp_pkg::SH_DR;
      jfp_pkg::SH_DR: tap_next = m ? jfp_pkg::EX1_DR : jfp_pkg::SH_DR;
      jfp_pkg::EX1_DR: tap_next = m ? jfp_pkg::UPD_DR : jfp_pkg::PAU_DR;
      jfp_pkg::PAU_DR: tap_next = m ? jfp_pkg::EX2_DR : jfp_pkg::PAU_DR;
      jfp_pkg::EX2_DR: tap_next = m ? jfp_pkg::UPD_DR : jfp_pkg::SH_DR;
      jfp_pkg::UPD_DR: tap_next = m ? jfp_pkg::SEL_DR : jfp_pkg::RTI;
      jfp_pkg::SEL_IR: tap_next = m ? jfp_pkg::TLR : jfp_pkg::CAP_IR;
      jfp_pkg::CAP_IR: tap_next = m ? jfp_pkg::EX1_IR : jfp_pkg::SH_IR;
      jfp_pkg::SH_IR: tap_next = m ? jfp_pkg::EX1_IR : jfp_pkg::SH_IR;
      jfp_pkg::EX1_IR: tap_next = m ? jfp_pkg::UPD_IR : jfp_pkg::PAU_IR;
      jfp_pkg::PAU_IR: tap_next = m ? jfp_pkg::EX2_IR : jfp_pkg::PAU_IR;
      jfp_pkg::EX2_IR: tap_next = m ? jfp_pkg::UPD_IR : jfp_pkg::SH_IR;
      jfp_pkg::UPD_IR: tap_next = m ? jfp_pkg::SEL_DR : jfp_pkg::RTI;
      default: tap_next = jfp_pkg::TLR;
    endcase
  endfunction : tap_next

  jfp_pkg::jfp_tap_type state_ff;
  wire jfp_pkg::jfp_tap_type step_state = tap_next(state_ff, pin_s2_ff.tms);
  wire jfp_pkg::jfp_tap_type nxt_state =
    !port_en ? jfp_pkg::TLR : (tck_rise ? step_state : state_ff);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= jfp_pkg::TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // State events, each one sys_clk wide
  wire step = tck_rise & port_en;
  wire cap_ir = step & (state_ff == jfp_pkg::CAP_IR);
  wire sh_ir = step & (state_ff == jfp_pkg::SH_IR);
  wire upd_ir = step & (step_state == jfp_pkg::UPD_IR);
  wire cap_dr = step & (state_ff == jfp_pkg::CAP_DR);
  wire sh_dr = step & (state_ff == jfp_pkg::SH_DR);
  wire upd_dr = step & (step_state == jfp_pkg::UPD_DR);
  wire enter_rti = step & (step_state == jfp_pkg::RTI)
    & (state_ff != jfp_pkg::RTI); // R06

  // ==========================================================
  // Instruction register
  logic [`JFP_IR_W-1:0] ir_sh_ff;
  logic [`JFP_IR_W-1:0] ir_ff;
  wire in_tlr = (state_ff == jfp_pkg::TLR);
  wire sel_rst = (ir_ff == `JFP_OP_RESET); // R07
  wire sel_unl = (ir_ff == `JFP_OP_UNLOCK); // R09
  wire sel_cmd = (ir_ff == `JFP_OP_CMD); // R13
  wire sel_pld = (ir_ff == `JFP_OP_PLOAD); // R19

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ir_sh_ff <= `JFP_IR_CAPTURE;
      ir_ff <= `JFP_OP_BYPASS;
    end else begin
      if (cap_ir) begin
        ir_sh_ff <= `JFP_IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_ff <= {pin_s2_ff.tdi, ir_sh_ff[`JFP_IR_W-1:1]}; // R04
      end
      if (in_tlr) begin
        ir_ff <= `JFP_OP_BYPASS;
      end else if (upd_ir) begin
        ir_ff <= ir_sh_ff; // R05
      end
    end
  end

  // ==========================================================
  // Data registers
  logic rst_reg_ff;
  logic byp_ff;
  logic [`JFP_UNLOCK_W-1:0] unl_ff;
  logic [`JFP_CMD_W-1:0] cmd_sh_ff;
  logic [`JFP_CMD_W-1:0] nxt_cmd_sh;
  wire dti = pin_s2_ff.tdi;
  wire key_ok = (unl_ff == `JFP_UNLOCK_KEY);

  always_comb begin
    nxt_cmd_sh = cmd_sh_ff;
    if (sel_cmd && cap_dr) begin
      nxt_cmd_sh = cmd_result; // R14
    end else if (sel_cmd && sh_dr) begin
      nxt_cmd_sh = {dti, cmd_sh_ff[`JFP_CMD_W-1:1]}; // R15
    end else if (sel_pld && sh_dr) begin
      nxt_cmd_sh[`JFP_BYTE_W-1:0] =
        {dti, cmd_sh_ff[`JFP_BYTE_W-1:1]}; // R19
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_reg_ff <= 1'b0;
      byp_ff <= 1'b0;
      unl_ff <= '0; // R11
      cmd_sh_ff <= '0;
    end else begin
      if (sel_rst && sh_dr) begin
        rst_reg_ff <= dti; // R07
      end
      if (cap_dr) begin
        byp_ff <= 1'b0;
      end else if (sh_dr) begin
        byp_ff <= dti;
      end
      if (sel_unl && sh_dr) begin
        unl_ff <= {dti, unl_ff[`JFP_UNLOCK_W-1:1]}; // R09
      end
      cmd_sh_ff <= nxt_cmd_sh;
    end
  end

  // ==========================================================
  // Device reset and programming mode
  logic dev_rst_ff;
  logic pmode_ff;
  logic [`JFP_TMO_W-1:0] tmo_ff;
  wire rst_req = rst_reg_ff | ~pin_s2_ff.ext_rst_n; // R12

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dev_rst_ff <= 1'b1;
      tmo_ff <= `JFP_RST_TMO_CYC;
      pmode_ff <= 1'b0;
    end else begin
      dev_rst_ff <= rst_req | (tmo_ff != '0); // R08
      if (rst_req) begin
        tmo_ff <= `JFP_RST_TMO_CYC; // R12
      end else if (tmo_ff != '0) begin
        tmo_ff <= tmo_ff - `JFP_TMO_W'(1);
      end
      if (sel_unl && upd_dr) begin
        pmode_ff <= key_ok; // R10
      end
    end
  end

  // ==========================================================
  // Commands and page load
  jfp_pkg::jfp_cmd_type cmd_ff;
  jfp_pkg::jfp_pbuf_type pend_ff;
  jfp_pkg::jfp_pbuf_type pbuf_ff;
  logic exec_ff;
  logic hi_ff;
  logic first_ff;
  logic [`JFP_ADDR_W-1:0] waddr_ff;
  wire cmd_upd = sel_cmd & upd_dr & pmode_ff; // R23
  wire pld_upd = sel_pld & upd_dr & pmode_ff; // R23
  wire pld_enter = upd_ir & (ir_sh_ff == `JFP_OP_PLOAD);
  wire [6:0] cmd_pfx = cmd_sh_ff[`JFP_CMD_W-1:`JFP_BYTE_W];
  wire [7:0] cmd_arg = cmd_sh_ff[`JFP_BYTE_W-1:0];
  wire addr_inc = ~hi_ff & ~first_ff; // R22
  wire [`JFP_ADDR_W-1:0] nxt_waddr =
    waddr_ff + {{(`JFP_ADDR_W-1){1'b0}}, addr_inc};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_ff <= '0;
      exec_ff <= 1'b0;
      waddr_ff <= '0;
    end else begin
      cmd_ff.apply <= cmd_upd;
      if (cmd_upd) begin
        cmd_ff.word <= cmd_sh_ff; // R16
      end
      exec_ff <= enter_rti & sel_cmd & pmode_ff; // R17
      if (cmd_upd && cmd_pfx == `JFP_PFX_ADDR_HI) begin
        waddr_ff[15:8] <= cmd_arg; // R18
      end else if (cmd_upd && cmd_pfx == `JFP_PFX_ADDR_LO) begin
        waddr_ff[7:0] <= cmd_arg; // R18
      end else if (pld_upd) begin
        waddr_ff <= nxt_waddr; // R22
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hi_ff <= 1'b0;
      first_ff <= 1'b1;
      pend_ff <= '0;
      pbuf_ff <= '0;
    end else begin
      if (pld_enter) begin
        hi_ff <= 1'b0; // R21
        first_ff <= 1'b1;
      end else if (pld_upd) begin
        hi_ff <= ~hi_ff; // R21
        first_ff <= 1'b0;
      end
      pend_ff <= '{we: pld_upd, hi: hi_ff, addr: nxt_waddr,
                   data: cmd_arg}; // R20
      pbuf_ff <= pend_ff; // R20
    end
  end

  // ==========================================================
  // Serial output, changes on the falling test clock
  logic tdo_ff;
  logic tdo_oe_ff;
  logic sel_bit;

  always_comb begin
    sel_bit = byp_ff;
    if (state_ff == jfp_pkg::SH_IR) begin
      sel_bit = ir_sh_ff[0];
    end else if (sel_rst) begin
      sel_bit = rst_reg_ff;
    end else if (sel_unl) begin
      sel_bit = unl_ff[0];
    end else if (sel_cmd || sel_pld) begin
      sel_bit = cmd_sh_ff[0]; // R04
    end
  end

  wire in_shift = (state_ff == jfp_pkg::SH_IR)
    | (state_ff == jfp_pkg::SH_DR);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (!port_en) begin
      tdo_oe_ff <= 1'b0; // R02
    end else if (tck_fall) begin
      tdo_ff <= sel_bit;
      tdo_oe_ff <= in_shift;
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
  assign scan_port_disable_bit = dis_ff;
  assign dev_reset = dev_rst_ff;
  assign prog_mode = pmode_ff;
  assign nvm_cmd = cmd_ff;
  assign nvm_exec_clk = exec_ff;
  assign pbuf_wr = pbuf_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_port_off: assert property (!port_en |=> state_ff == jfp_pkg::TLR) // R02
    else $error("controller not held while port disabled");
  a_dis_clear: assert property ((dis_rst_low && !dis_wr)[*2]
    |=> !dis_ff) // R03
    else $error("disable bit not cleared after two clocks");
  a_lsb_first: assert property (sel_cmd && sh_dr
    |=> cmd_sh_ff[14] == $past(dti)) // R04
    else $error("serial in not entering at the top bit");
  a_rst_follow: assert property (rst_reg_ff |=> dev_rst_ff) // R08
    else $error("device not in reset with reset bit set");
  a_unlock_ok: assert property (sel_unl && upd_dr && key_ok
    |=> pmode_ff) // R10
    else $error("matching key did not unlock");
  a_unlock_bad: assert property (sel_unl && upd_dr && !key_ok
    |=> !pmode_ff) // R11
    else $error("wrong key unlocked programming");
  a_cmd_locked: assert property (cmd_ff.apply
    |-> $past(pmode_ff) && cmd_ff.word == $past(cmd_sh_ff)) // R23
    else $error("command applied while locked or wrong word");
  a_exec_once: assert property (exec_ff |=> !exec_ff) // R17
    else $error("execute clock longer than one cycle");
  a_first_low: assert property (pld_upd && first_ff
    |-> ##2 pbuf_ff.we && !pbuf_ff.hi
    && pbuf_ff.addr == $past(waddr_ff, 2)) // R22
    else $error("first page byte not low at preset address");
  a_pload_lat: assert property (pld_upd
    |-> ##2 pbuf_ff.we && pbuf_ff.hi == $past(hi_ff, 2)) // R20
    else $error("page byte not written in time");
endmodule : jfp_access

//--- rtl/jfp_cfg.svh
// Constants of the scan-port flash programming access block.
// Assumes inclusion by bare name from the block's sources.
`ifndef JFP_CFG_SVH
`define JFP_CFG_SVH
// ==========================================================
// Instruction opcodes
`define JFP_IR_W 4
`define JFP_OP_RESET 4'hc
`define JFP_OP_UNLOCK 4'h4
`define JFP_OP_CMD 4'h5
`define JFP_OP_PLOAD 4'h6
`define JFP_OP_BYPASS 4'hf
`define JFP_IR_CAPTURE 4'h1
// ==========================================================
// Data registers and command prefixes
`define JFP_UNLOCK_W 16
`define JFP_UNLOCK_KEY 16'ha370
`define JFP_CMD_W 15
`define JFP_BYTE_W 8
`define JFP_ADDR_W 16
`define JFP_PFX_ADDR_HI 7'h07
`define JFP_PFX_ADDR_LO 7'h03
// ==========================================================
// Timing counts in sys_clk cycles
`define JFP_DIS_CLR_CYC 2'h2
`define JFP_RST_TMO_CYC 5'h10
`define JFP_TMO_W 5
`endif

//--- rtl/jfp_pkg.sv
// Types shared by the scan-port flash programming access block.
// Assumes jfp_cfg.svh is on the include path.
`include "jfp_cfg.svh"
package jfp_pkg;
  // ==========================================================
  // Test-access controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jfp_tap_type;
  // Sampled pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic ext_rst_n;
  } jfp_pin_type;
  // Command word applied to the memory control inputs
  typedef struct packed {
    logic apply;
    logic [`JFP_CMD_W-1:0] word;
  } jfp_cmd_type;
  // One byte write into the flash page buffer
  typedef struct packed {
    logic we;
    logic hi;
    logic [`JFP_ADDR_W-1:0] addr;
    logic [`JFP_BYTE_W-1:0] data;
  } jfp_pbuf_type;
endpackage : jfp_pkg

//--- testbench/jfp_host_model.sv
// Programmer model: drives tck, tms, tdi and samples tdo.
// Assumes sys_clk from the bench; tck rests low between frames.
module jfp_host_model (
  // Clock
  input wire logic sys_clk,
  // Test-port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic at_sel;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    at_sel = 1'b0;
  end
  // ==========
  // One tck period of eight sys_clk cycles, tdo sampled before the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge sys_clk);
    tms = m;
    tdi = d;
    repeat (2) @(negedge sys_clk);
    q = tdo;
    tck = 1'b1;
    repeat (3) @(negedge sys_clk);
    tck = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : step
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
    at_sel = 1'b0;
  endtask : reset_tap
  // Shift n bits through IR or DR; idle ends in Run-Test/Idle
  task automatic shift(input logic [15:0] v, input int n, input logic ir,
                       input logic idle, output logic [15:0] q);
    logic b;
    q = 16'h0000;
    if (!at_sel) step(1'b1, ~tdi, b);
    if (ir) step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
    step(1'b0, ~tdi, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], b);
      q[i] = b;
    end
    step(1'b1, ~tdi, b);
    step(!idle, ~tdi, b);
    at_sel = !idle;
  endtask : shift
endmodule : jfp_host_model

//--- testbench/jfp_access_tb.sv
// Self-checking bench of the scan-port flash programming access block.
// Assumes jfp_pkg, jfp_access and jfp_host_model are compiled first.
module jfp_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Hookup
  logic sys_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, ext_rst_n, fuse;
  logic dis_wr, dis_wr_val, dis_bit, dev_reset, prog_mode, exec_clk;
  logic [14:0] cmd_result;
  logic [15:0] q;
  jfp_pkg::jfp_cmd_type nvm_cmd;
  jfp_pkg::jfp_pbuf_type pbuf_wr;
  jfp_pkg::jfp_pbuf_type wr_log [8];
  int n_errors, samples_checked, n_apply, n_exec, n_we, n_oe;
  jfp_access dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ext_rst_n(ext_rst_n),
    .scan_port_enable_fuse(fuse), .dis_wr(dis_wr), .dis_wr_val(dis_wr_val),
    .scan_port_disable_bit(dis_bit), .dev_reset(dev_reset),
    .prog_mode(prog_mode), .cmd_result(cmd_result), .nvm_cmd(nvm_cmd),
    .nvm_exec_clk(exec_clk), .pbuf_wr(pbuf_wr));
  jfp_host_model host_u (.sys_clk(sys_clk), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Pulse counters and page-buffer write log
  always @(posedge sys_clk) begin
    if (nvm_cmd.apply === 1'b1) n_apply++;
    if (exec_clk === 1'b1) n_exec++;
    if (tdo_oe === 1'b1) n_oe++;
    if (pbuf_wr.we === 1'b1) begin
      wr_log[n_we % 8] = pbuf_wr;
      n_we++;
    end
  end
  // ==========
  // Helpers
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check
  task automatic ir(input logic [3:0] op);
    host_u.shift({12'h000, op}, 4, 1'b1, 1'b1, q);
  endtask : ir
  task automatic dr(input logic [15:0] v, input int n, input logic idle);
    host_u.shift(v, n, 1'b0, idle, q);
  endtask : dr
  task automatic results();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // ==========
  // Scenarios
  task automatic t_reset();
    @(negedge sys_clk);
    check("dev_reset held", 16'h1, dev_reset);
    check("prog_mode idle", 16'h0, prog_mode);
    repeat (20) @(negedge sys_clk);
    check("dev_reset timeout", 16'h0, dev_reset);
  endtask : t_reset
  task automatic t_ir();
    int oe0;
    host_u.reset_tap();
    oe0 = n_oe;
    ir(4'hf);
    check("ir capture", 16'h1, q);
    check("oe in shift", 16'h1, 16'(n_oe > oe0));
  endtask : t_ir
  task automatic t_devrst();
    ir(4'hc);
    dr(16'h1, 1, 1'b1);
    check("reset bit on", 16'h1, dev_reset);
    dr(16'h0, 1, 1'b1);
    check("reset bit out", 16'h1, q);
    repeat (24) @(negedge sys_clk);
    check("reset bit off", 16'h0, dev_reset);
  endtask : t_devrst
  task automatic t_locked();
    ir(4'h5);
    dr(16'h2310, 15, 1'b1);
    ir(4'h6);
    dr(16'h0055, 8, 1'b0);
    check("locked pulses", 16'h0, 16'(n_apply + n_exec + n_we));
  endtask : t_locked
  task automatic t_unlock();
    ir(4'h4);
    dr(16'ha371, 16, 1'b1);
    check("bad key", 16'h0, prog_mode);
    dr(16'ha370, 16, 1'b1);
    check("good key", 16'h1, prog_mode);
  endtask : t_unlock
  task automatic t_cmd();
    // Idle after the instruction update already counts as one execute clock
    ir(4'h5);
    check("exec on ir idle", 16'h1, 16'(n_exec));
    dr(16'h2310, 15, 1'b1);
    check("result out", {1'b0, cmd_result}, q);
    check("cmd word", 16'h2310, {1'b0, nvm_cmd.word});
    check("apply count", 16'h1, 16'(n_apply));
    check("exec count", 16'h2, 16'(n_exec));
    dr(16'h0712, 15, 1'b0);
    check("second result", {1'b0, cmd_result}, q);
    dr(16'h0340, 15, 1'b0);
    check("exec idle only", 16'h2, 16'(n_exec));
    check("apply total", 16'h3, 16'(n_apply));
  endtask : t_cmd
  task automatic t_pload();
    ir(4'h6);
    for (int i = 0; i < 4; i++) begin
      dr({8'h00, 8'h31 + 8'(i)}, 8, 1'b0);
      check("page write count", 16'(i + 1), 16'(n_we));
    end
    for (int i = 0; i < 4; i++) begin
      check("byte half", 16'(i % 2), {15'h0, wr_log[i].hi});
      check("word address", 16'h1240 + 16'(i / 2), wr_log[i].addr);
      check("page byte", 16'h31 + 16'(i), {8'h00, wr_log[i].data});
    end
  endtask : t_pload
  task automatic t_disable();
    int oe0;
    dis_wr = 1'b1;
    dis_wr_val = 1'b1;
    @(negedge sys_clk);
    dis_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("disable set", 16'h1, dis_bit);
    oe0 = n_oe;
    host_u.reset_tap();
    ir(4'hf);
    check("port closed", 16'(oe0), 16'(n_oe));
    ext_rst_n = 1'b0;
    @(negedge sys_clk);
    check("disable held", 16'h1, dis_bit);
    repeat (8) @(negedge sys_clk);
    check("disable cleared", 16'h0, dis_bit);
    check("pin reset", 16'h1, dev_reset);
    ext_rst_n = 1'b1;
    fuse = 1'b0;
    ir(4'hf);
    check("fuse off", 16'(oe0), 16'(n_oe));
    fuse = 1'b1;
    repeat (30) @(negedge sys_clk);
  endtask : t_disable
  // ==========
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    ext_rst_n = 1'b1;
    fuse = 1'b1;
    dis_wr = 1'b0;
    dis_wr_val = 1'b0;
    cmd_result = 15'h2a5a;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_ir();
    t_devrst();
    t_locked();
    t_unlock();
    t_cmd();
    t_pload();
    t_disable();
    t_ir();
    results();
  end
  initial begin
    #2000000;
    n_errors++;
    results();
  end
endmodule : jfp_access_tb
